// File: hw/atid_consts.vh
// Opcodes, field positions and reset values of the accumulator transfer decoder
`ifndef ATID_CONSTS_VH
`define ATID_CONSTS_VH

// ----------------------------------------------------------------
// Instruction word
// ----------------------------------------------------------------
`define ATID_INSN_W          10
`define ATID_NIB_W           4
`define ATID_IMM_MSB         3
`define ATID_IMM_LSB         0
`define ATID_PFX_MSB         9
`define ATID_PFX_LSB         4

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define ATID_OPC_STORE_PFX   6'h2B
`define ATID_OPC_LD_CLK      10'h216
`define ATID_OPC_LD_PU0      10'h22D
`define ATID_OPC_LD_PU1      10'h22E

// ----------------------------------------------------------------
// Control register slots and reset values
// ----------------------------------------------------------------
`define ATID_NUM_CTRL        3
`define ATID_SLOT_CLK        0
`define ATID_SLOT_PU0        1
`define ATID_SLOT_PU1        2
`define ATID_CTRL_RST        4'h0
`define ATID_RSTSYNC_RST     1'h0
`define ATID_RSTSYNC_REL     1'h1
`define ATID_FLAG_RST        1'h0
`define ATID_FLAG_OFF        1'h0

`endif

// File: hw/atid_ctrl_reg.v
// Loadable control register cleared by reset
module atid_ctrl_reg #(
    parameter W = 4
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         rst_n,
    // Load port
    input  wire         load,
    input  wire [W-1:0] d,
    // Value
    output reg  [W-1:0] q
);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= {W{1'b0}};
        end else if (load) begin
            q <= d;
        end
    end

endmodule

// File: hw/atid_decode.v
// Decoder and executor of four accumulator transfer instructions
//
// How it works
// - Store opcode 2Bj recognised, j any nibble
// - Store writes accumulator to RAM at pointer
// - Then file register becomes itself xor j
// - Opcode 216 copies accumulator to clock control
// - Clock control output follows the new value
// - Opcode 22D copies accumulator to pull-up zero
// - Opcode 22E copies accumulator to pull-up one
`include "atid_consts.vh"

module atid_decode #(
    parameter DP_W = 8
) (
    // Clock and reset
    input  wire                     core_clk,
    input  wire                     resetn,
    // Instruction from fetch
    input  wire                     insn_valid,
    input  wire [`ATID_INSN_W-1:0]  insn_word,
    // CPU register values
    input  wire [`ATID_NIB_W-1:0]   acc,
    input  wire [DP_W-1:0]          data_pointer,
    input  wire [`ATID_NIB_W-1:0]   file_reg,
    // RAM write port
    output wire                     ram_wr_en,
    output wire [DP_W-1:0]          ram_wr_addr,
    output wire [`ATID_NIB_W-1:0]   ram_wr_data,
    // File register write port
    output wire                     file_reg_wr_en,
    output wire [`ATID_NIB_W-1:0]   file_reg_wr_data,
    // Flag and sequencing
    output wire                     insn_done,
    output wire                     carry_flag_wr_en,
    output wire                     skip_next,
    // Control registers
    output wire [`ATID_NIB_W-1:0]   clock_control_reg,
    output wire [`ATID_NIB_W-1:0]   pullup_control_zero,
    output wire [`ATID_NIB_W-1:0]   pullup_control_one
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg rst_sync1_reg;
    reg rst_sync2_reg;
    wire rst_n;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync1_reg <= `ATID_RSTSYNC_RST;
            rst_sync2_reg <= `ATID_RSTSYNC_RST;
        end else begin
            rst_sync1_reg <= `ATID_RSTSYNC_REL;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    assign rst_n = rst_sync2_reg;

    // ------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------
    wire [`ATID_NIB_W-1:0]               imm_j;
    wire [`ATID_PFX_MSB-`ATID_PFX_LSB:0] opc_prefix;
    wire                                 match_store;
    wire                                 match_ld_clk;
    wire                                 match_ld_pu0;
    wire                                 match_ld_pu1;
    wire                                 is_store;
    wire                                 is_ld_clk;
    wire                                 is_ld_pu0;
    wire                                 is_ld_pu1;

    assign imm_j        = insn_word[`ATID_IMM_MSB:`ATID_IMM_LSB];
    assign opc_prefix   = insn_word[`ATID_PFX_MSB:`ATID_PFX_LSB];
    assign match_store  = (opc_prefix == `ATID_OPC_STORE_PFX);
    assign match_ld_clk = (insn_word == `ATID_OPC_LD_CLK);
    assign match_ld_pu0 = (insn_word == `ATID_OPC_LD_PU0);
    assign match_ld_pu1 = (insn_word == `ATID_OPC_LD_PU1);

    // Only a valid word takes effect
    assign is_store     = insn_valid && match_store;
    assign is_ld_clk    = insn_valid && match_ld_clk;
    assign is_ld_pu0    = insn_valid && match_ld_pu0;
    assign is_ld_pu1    = insn_valid && match_ld_pu1;

    // ------------------------------------------------------------
    // Next values of the RAM and file register writes
    // ------------------------------------------------------------
    reg                   ram_wr_en_next;
    reg [DP_W-1:0]        ram_wr_addr_next;
    reg [`ATID_NIB_W-1:0] ram_wr_data_next;
    reg                   file_wr_en_next;
    reg [`ATID_NIB_W-1:0] file_wr_data_next;

    always @* begin
        // Address taken from the pointer before the file register moves
        ram_wr_en_next    = is_store;
        ram_wr_addr_next  = data_pointer;
        ram_wr_data_next  = acc;
        file_wr_en_next   = is_store;
        file_wr_data_next = file_reg ^ imm_j;
    end

    // ------------------------------------------------------------
    // Next values of the status flags
    // ------------------------------------------------------------
    reg                   done_next;
    reg                   carry_wr_next;
    reg                   skip_flag_next;

    always @* begin
        done_next      = is_store | is_ld_clk | is_ld_pu0 | is_ld_pu1;
        carry_wr_next  = `ATID_FLAG_OFF;
        skip_flag_next = `ATID_FLAG_OFF;
    end

    // ------------------------------------------------------------
    // RAM write port
    // ------------------------------------------------------------
    reg                   ram_wr_en_reg;
    reg [DP_W-1:0]        ram_wr_addr_reg;
    reg [`ATID_NIB_W-1:0] ram_wr_data_reg;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_wr_en_reg   <= `ATID_FLAG_RST;
            ram_wr_addr_reg <= {DP_W{`ATID_FLAG_RST}};
            ram_wr_data_reg <= `ATID_CTRL_RST;
        end else begin
            ram_wr_en_reg   <= ram_wr_en_next;
            ram_wr_addr_reg <= ram_wr_addr_next;
            ram_wr_data_reg <= ram_wr_data_next;
        end
    end

    // ------------------------------------------------------------
    // File register write port
    // ------------------------------------------------------------
    reg                   file_wr_en_reg;
    reg [`ATID_NIB_W-1:0] file_wr_data_reg;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_wr_en_reg   <= `ATID_FLAG_RST;
            file_wr_data_reg <= `ATID_CTRL_RST;
        end else begin
            file_wr_en_reg   <= file_wr_en_next;
            file_wr_data_reg <= file_wr_data_next;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    reg                   done_reg;
    reg                   carry_wr_reg;
    reg                   skip_flag_reg;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg      <= `ATID_FLAG_RST;
            carry_wr_reg  <= `ATID_FLAG_RST;
            skip_flag_reg <= `ATID_FLAG_RST;
        end else begin
            done_reg      <= done_next;
            carry_wr_reg  <= carry_wr_next;
            skip_flag_reg <= skip_flag_next;
        end
    end

    // ------------------------------------------------------------
    // Control load strobes
    // ------------------------------------------------------------
    wire [`ATID_NUM_CTRL-1:0]             ctrl_load;
    wire [`ATID_NUM_CTRL*`ATID_NIB_W-1:0] ctrl_q;

    assign ctrl_load[`ATID_SLOT_CLK] = is_ld_clk;
    assign ctrl_load[`ATID_SLOT_PU0] = is_ld_pu0;
    assign ctrl_load[`ATID_SLOT_PU1] = is_ld_pu1;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `ATID_NUM_CTRL; i = i + 1) begin : g_ctrl
            atid_ctrl_reg #(
                .W (`ATID_NIB_W)
            ) u_ctrl (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .load     (ctrl_load[i]),
                .d        (acc),
                .q        (ctrl_q[i*`ATID_NIB_W +: `ATID_NIB_W])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // RAM and file register outputs
    // ------------------------------------------------------------
    assign ram_wr_en           = ram_wr_en_reg;
    assign ram_wr_addr         = ram_wr_addr_reg;
    assign ram_wr_data         = ram_wr_data_reg;
    assign file_reg_wr_en      = file_wr_en_reg;
    assign file_reg_wr_data    = file_wr_data_reg;

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    assign insn_done           = done_reg;
    assign carry_flag_wr_en    = carry_wr_reg;
    assign skip_next           = skip_flag_reg;

    // ------------------------------------------------------------
    // Control register outputs
    // ------------------------------------------------------------
    assign clock_control_reg   = ctrl_q[`ATID_SLOT_CLK*`ATID_NIB_W +: `ATID_NIB_W];
    assign pullup_control_zero = ctrl_q[`ATID_SLOT_PU0*`ATID_NIB_W +: `ATID_NIB_W];
    assign pullup_control_one  = ctrl_q[`ATID_SLOT_PU1*`ATID_NIB_W +: `ATID_NIB_W];

endmodule

// File: verification/atid_cpu_model.sv
// Instruction source and CPU register model facing the decoder
module atid_cpu_model (
    // Clock and write ports
    input  wire        core_clk, ram_wr_en, file_reg_wr_en,
    input  wire  [7:0] ram_wr_addr,
    input  wire  [3:0] ram_wr_data, file_reg_wr_data,
    // Instruction and registers
    output logic       insn_valid,
    output logic [9:0] insn_word,
    output logic [3:0] acc, file_reg,
    output logic [7:0] data_pointer
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] ram [0:255];
    initial {insn_valid, insn_word, acc, file_reg, data_pointer} = '0;
    always @(posedge core_clk) begin
        if (ram_wr_en) ram[ram_wr_addr] <= ram_wr_data;
        if (file_reg_wr_en) file_reg <= file_reg_wr_data;
    end
    task run(input logic [9:0] w, input logic [3:0] a, input logic [7:0] p);
        @(posedge core_clk);
        #1 {insn_valid, insn_word, acc, data_pointer} = {1'b1, w, a, p};
    endtask
    // Released lines show inverted values, not stale ones
    task idle;
        @(posedge core_clk);
        #1 {insn_valid, insn_word, acc, data_pointer} = {1'b0, ~insn_word, ~acc, ~data_pointer};
    endtask
endmodule

// File: verification/atid_decode_props.sv
// Assertion checker for the accumulator transfer decoder
module atid_decode_props #(
    parameter DP_W = 8
) (
    // Clock and reset
    input wire            core_clk,
    input wire            resetn,
    // Instruction and CPU registers
    input wire            insn_valid,
    input wire [9:0]      insn_word,
    input wire [3:0]      acc,
    input wire [3:0]      file_reg,
    input wire [DP_W-1:0] data_pointer,
    // Results
    input wire            ram_wr_en,
    input wire [DP_W-1:0] ram_wr_addr,
    input wire [3:0]      ram_wr_data,
    input wire            file_reg_wr_en,
    input wire [3:0]      file_reg_wr_data,
    input wire            insn_done,
    input wire            carry_flag_wr_en,
    input wire            skip_next,
    input wire [3:0]      clock_control_reg,
    input wire [3:0]      pullup_control_zero,
    input wire [3:0]      pullup_control_one
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire st = insn_valid && insn_word[9:4] == 6'h2B;
    wire lc = insn_valid && insn_word == 10'h216;
    wire l0 = insn_valid && insn_word == 10'h22D;
    wire l1 = insn_valid && insn_word == 10'h22E;
    sequence s_wr;
        ram_wr_en && ram_wr_addr == $past(data_pointer) && ram_wr_data == $past(acc);
    endsequence
    sequence s_xor;
        file_reg_wr_en && file_reg_wr_data == ($past(file_reg) ^ $past(insn_word[3:0]));
    endsequence
    AST_STORE_WR: assert property (st |=> s_wr) else $error("store");
    AST_STORE_XOR: assert property (st |=> s_xor) else $error("xor");
    AST_LD_CLK: assert property (lc |=> clock_control_reg == $past(acc)) else $error("clk");
    AST_CLK_HOLD: assert property (!lc |=> $stable(clock_control_reg)) else $error("hold");
    AST_LD_PU0: assert property (l0 |=> pullup_control_zero == $past(acc)) else $error("p0");
    AST_LD_PU1: assert property (l1 |=> pullup_control_one == $past(acc)) else $error("p1");
    AST_DONE: assert property ((st || lc || l0 || l1) |=> insn_done && !skip_next
        && !carry_flag_wr_en) else $error("done");
    AST_IGNORE: assert property (!(st || lc || l0 || l1) |=> !insn_done && !ram_wr_en
        && !file_reg_wr_en) else $error("ignore");
    AST_PU0_HOLD: assert property (!l0 |=> $stable(pullup_control_zero)) else $error("hold0");
    AST_PU1_HOLD: assert property (!l1 |=> $stable(pullup_control_one)) else $error("hold1");
endmodule

bind atid_decode atid_decode_props #(
    .DP_W (DP_W)
) u_props (
    .core_clk            (core_clk),
    .resetn              (resetn),
    .insn_valid          (insn_valid),
    .insn_word           (insn_word),
    .acc                 (acc),
    .file_reg            (file_reg),
    .data_pointer        (data_pointer),
    .ram_wr_en           (ram_wr_en),
    .ram_wr_addr         (ram_wr_addr),
    .ram_wr_data         (ram_wr_data),
    .file_reg_wr_en      (file_reg_wr_en),
    .file_reg_wr_data    (file_reg_wr_data),
    .insn_done           (insn_done),
    .carry_flag_wr_en    (carry_flag_wr_en),
    .skip_next           (skip_next),
    .clock_control_reg   (clock_control_reg),
    .pullup_control_zero (pullup_control_zero),
    .pullup_control_one  (pullup_control_one)
);

// File: verification/tb.sv
// Self-checking testbench for the accumulator transfer decoder
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    int miscompares = 0;
    int cmp_count = 0;
    logic [3:0] x;
    wire insn_valid, ram_wr_en, file_reg_wr_en, insn_done, carry_flag_wr_en, skip_next;
    wire [9:0] insn_word;
    wire [3:0] acc, file_reg, ram_wr_data, file_reg_wr_data;
    wire [3:0] clock_control_reg, pullup_control_zero, pullup_control_one;
    wire [7:0] data_pointer, ram_wr_addr;
    always #2.5 core_clk = ~core_clk;
    atid_cpu_model m (
        .core_clk         (core_clk),
        .ram_wr_en        (ram_wr_en),
        .file_reg_wr_en   (file_reg_wr_en),
        .ram_wr_addr      (ram_wr_addr),
        .ram_wr_data      (ram_wr_data),
        .file_reg_wr_data (file_reg_wr_data),
        .insn_valid       (insn_valid),
        .insn_word        (insn_word),
        .acc              (acc),
        .file_reg         (file_reg),
        .data_pointer     (data_pointer)
    );
    atid_decode #(
        .DP_W (8)
    ) dut (
        .core_clk            (core_clk),
        .resetn              (resetn),
        .insn_valid          (insn_valid),
        .insn_word           (insn_word),
        .acc                 (acc),
        .data_pointer        (data_pointer),
        .file_reg            (file_reg),
        .ram_wr_en           (ram_wr_en),
        .ram_wr_addr         (ram_wr_addr),
        .ram_wr_data         (ram_wr_data),
        .file_reg_wr_en      (file_reg_wr_en),
        .file_reg_wr_data    (file_reg_wr_data),
        .insn_done           (insn_done),
        .carry_flag_wr_en    (carry_flag_wr_en),
        .skip_next           (skip_next),
        .clock_control_reg   (clock_control_reg),
        .pullup_control_zero (pullup_control_zero),
        .pullup_control_one  (pullup_control_one)
    );
    task chk(input logic ok, input string s);
        cmp_count++;
        if (!ok) begin
            $display("[ERR] %0t %s", $time, s);
            miscompares++;
        end
    endtask
    task complete_run;
        $display("mismatches %0d checks %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task t_store;
        x = file_reg;
        for (int j = 0; j < 16; j++) begin
            m.run({6'h2B, j[3:0]}, 4'hF - j[3:0], 8'h40 + j[7:0]);
            m.idle;
            chk(ram_wr_en === 1'b1 && ram_wr_addr === 8'h40 + j[7:0], "ram addr");
            chk(ram_wr_data === 4'hF - j[3:0] && insn_done === 1'b1, "ram data");
            chk(carry_flag_wr_en === 1'b0 && skip_next === 1'b0, "flags");
            chk(file_reg_wr_en === 1'b1 && file_reg_wr_data === (x ^ j[3:0]), "xor");
            x = x ^ j[3:0];
        end
        m.idle;
        chk(m.ram[8'h45] === 4'hA && ram_wr_en === 1'b0 && skip_next === 1'b0, "end");
    endtask
    task t_loads;
        m.run(10'h216, 4'h9, 8'h00);
        m.run(10'h22D, 4'hA, 8'h00);
        chk(clock_control_reg === 4'h9 && insn_done === 1'b1, "clk ctrl");
        chk(carry_flag_wr_en === 1'b0 && skip_next === 1'b0, "load flags");
        m.run(10'h22E, 4'hC, 8'h00);
        chk(pullup_control_zero === 4'hA && clock_control_reg === 4'h9, "pu0");
        m.idle;
        chk(pullup_control_one === 4'hC && ram_wr_en === 1'b0, "pu1");
        m.idle;
        chk(insn_done === 1'b0 && carry_flag_wr_en === 1'b0, "quiet");
    endtask
    task t_refuse;
        logic [9:0] bad [6] = '{10'h2AF, 10'h2C0, 10'h217, 10'h215, 10'h22C, 10'h22F};
        foreach (bad[i]) begin
            m.run(bad[i], 4'h5, 8'h00);
            m.idle;
            chk(insn_done === 1'b0 && ram_wr_en === 1'b0 && {clock_control_reg,
                pullup_control_zero, pullup_control_one} === 12'h9AC, "refuse");
        end
    endtask
    task t_reset;
        resetn = 1'b0;
        #1 chk({clock_control_reg, pullup_control_zero,
            pullup_control_one} === 12'h000, "reset");
        repeat (3) @(posedge core_clk);
        #1 resetn = 1'b1;
        repeat (2) begin
            @(posedge core_clk);
            #1 chk({ram_wr_en, file_reg_wr_en, insn_done,
                clock_control_reg} === 7'h00, "held");
        end
        @(posedge core_clk);
        m.run(10'h216, 4'h3, 8'h00);
        m.idle;
        chk(clock_control_reg === 4'h3, "reload");
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge core_clk);
        t_store;
        t_loads;
        t_refuse;
        t_reset;
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        complete_run;
    end
endmodule
